// ==== common/ebu_defs_defs.vh ====
// constants for the external bus cycle sequencer
`ifndef EBU_DEFS_DEFS_VH
`define EBU_DEFS_DEFS_VH
// register bus
`define RB_AW 8
`define REG_CFG 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_CMD 8'h0c
`define REG_STAT 8'h10
`define REG_RDATA 8'h14
// chip_select_timing_config fields
`define CFG_W 18
`define CFG_RST 18'h00001
`define CFG_AB_HI 2
`define CFG_AB_LO 0
`define CFG_C_HI 4
`define CFG_C_LO 3
`define CFG_D 5
`define CFG_E_HI 10
`define CFG_E_LO 6
`define CFG_F_HI 12
`define CFG_F_LO 11
`define CFG_RDY_EN 13
`define CFG_RDY_POL 14
`define CFG_RDY_ASYNC 15
`define CFG_MUX 16
`define CFG_EXT_PCLK 17
// command bits
`define CMD_GO 0
`define CMD_RNW 1
// phase lengths in phase_clock_unit
`define LEN_W 6
`define AB_ONE 3'h1
`define AB_TWO 3'h2
`define AB_FIVE 3'h5
`define LEN_ZERO 6'h00
`define LEN_ONE 6'h01
// bus width, address width
`define AW 24
`define DW 16
`define ADDR_RST 24'h000000
`define DATA_RST 16'h0000
`define RDATA_RST 32'h00000000
// transition spacing and system clock
`define MIN_TRANS_PS 12500
`define CLK_PERIOD_PS 10000
`define MIN_TRANS_CYC ((`MIN_TRANS_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DIV_W 4
`endif

// ==== hdl/external_bus_cycle_sequencer.v ====
// external bus cycle sequencer with five programmable phases
//
// Summary of operation
// - every bus cycle runs address, second, third, access and final phase in that order; second, third and final phases of length 0 are skipped.
// - phase lengths come from the software-written chip_select_timing_config register.
// - lengths are address 1, 2 or 5, second 0-3, third 0-1, access 1-32, final 0-3 units.
// - with ready control on, the attached module stretches or ends the access phase.
// - with internal unit timing each phase unit spans at least 12.5 ns so bus pins never toggle faster.
// - the reference clock output is the system clock routed to the pin.
// - read data are captured on the edge that ends the read strobe.
// - data captured at that edge are not disturbed by later address or data changes.
// - multiplexed mode shares 16 lines for address then data; separate mode has 24+16 lines.
// - the active level of ready is chosen by configuration.
// - ready inactive at the sample point adds a waitstate, active ends the access phase.
// - asynchronous ready passes one extra flop stage, costing at most one waitstate.
`timescale 1ns/1ps
`default_nettype none
`include "ebu_defs_defs.vh"
module external_bus_cycle_sequencer (
  input wire mclk,
  input wire rst,
  input wire [`RB_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire reference_clock_out,
  input wire phase_clk,
  input wire ready_pin,
  output reg cs_n,
  output reg ale,
  output reg rd_n,
  output reg wr_n,
  output reg byte_high_enable_n,
  output reg [`AW-1:0] address_bus,
  input wire [`DW-1:0] shared_addr_data_lines_i,
  output reg [`DW-1:0] shared_addr_data_lines_o,
  output reg shared_addr_data_lines_oe,
  input wire [`DW-1:0] data_bus_i,
  output reg [`DW-1:0] data_bus_o,
  output reg data_bus_oe,
  output wire rd_word_valid,
  input wire rd_word_ready,
  output wire [`DW-1:0] rd_word
);

  // ==========================================================
  // states
  localparam S_IDLE = 6'h01;
  localparam S_AB = 6'h02;
  localparam S_C = 6'h04;
  localparam S_D = 6'h08;
  localparam S_E = 6'h10;
  localparam S_F = 6'h20;

  // ==========================================================
  // declarations
  reg [`CFG_W-1:0] cfg_q;
  reg [`AW-1:0] addr_q;
  reg [`DW-1:0] wdata_q;
  reg [`DW-1:0] last_rdata_q;
  reg rnw_q;
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [`LEN_W-1:0] cnt_q;
  reg [`LEN_W-1:0] cnt_d;
  reg [`DIV_W-1:0] div_q;
  reg pclk_prev_q;
  reg rdy_extra_q;
  reg start;
  reg capture;
  wire [33:0] pins_s;
  wire rdy_s;
  wire pclk_s;
  wire [`DW-1:0] shared_s;
  wire [`DW-1:0] dbus_s;
  wire tick;
  wire rdy_raw;
  wire rdy_active;
  wire multiplexed_mode;
  wire buf_in_ready;
  wire [1:0] buf_level;
  wire [`DW-1:0] cap_data;

  // ==========================================================
  // phase length decode
  function [`LEN_W-1:0] phase_len;
    input [5:0] st;
    input [`CFG_W-1:0] cfg;
    reg [2:0] ab;
    begin
      ab = cfg[`CFG_AB_HI:`CFG_AB_LO];
      case (st)
        S_AB: begin
          if (ab == `AB_ONE || ab == `AB_TWO || ab == `AB_FIVE) begin
            phase_len = {3'h0, ab};
          end else if (ab == 3'h0) begin
            phase_len = `LEN_ONE;
          end else begin
            phase_len = {3'h0, `AB_TWO};
          end
        end
        S_C: phase_len = {4'h0, cfg[`CFG_C_HI:`CFG_C_LO]};
        S_D: phase_len = {5'h00, cfg[`CFG_D]};
        S_E: phase_len = {1'b0, cfg[`CFG_E_HI:`CFG_E_LO]} + `LEN_ONE;
        S_F: phase_len = {4'h0, cfg[`CFG_F_HI:`CFG_F_LO]};
        default: phase_len = `LEN_ZERO;
      endcase
    end
  endfunction

  // ==========================================================
  // next phase, skipping empty ones
  function [5:0] next_phase;
    input [5:0] st;
    input [`CFG_W-1:0] cfg;
    begin
      case (st)
        S_IDLE: next_phase = S_AB;
        S_AB: begin
          if (phase_len(S_C, cfg) != `LEN_ZERO) begin
            next_phase = S_C;
          end else if (phase_len(S_D, cfg) != `LEN_ZERO) begin
            next_phase = S_D;
          end else begin
            next_phase = S_E;
          end
        end
        S_C: begin
          if (phase_len(S_D, cfg) != `LEN_ZERO) begin
            next_phase = S_D;
          end else begin
            next_phase = S_E;
          end
        end
        S_D: next_phase = S_E;
        S_E: begin
          if (phase_len(S_F, cfg) != `LEN_ZERO) begin
            next_phase = S_F;
          end else begin
            next_phase = S_IDLE;
          end
        end
        default: next_phase = S_IDLE;
      endcase
    end
  endfunction

  // ==========================================================
  // reference clock
  assign reference_clock_out = mclk;

  // ==========================================================
  // pin synchronisers
  pin_sync2 #(
    .W(34)
  ) pin_sync2_inst (
    .mclk(mclk),
    .rst(rst),
    .pin({ready_pin, phase_clk, shared_addr_data_lines_i, data_bus_i}),
    .sync(pins_s)
  );

  assign rdy_s = pins_s[33];
  assign pclk_s = pins_s[32];
  assign shared_s = pins_s[31:16];
  assign dbus_s = pins_s[15:0];
  assign multiplexed_mode = cfg_q[`CFG_MUX];

  // ==========================================================
  // phase unit timing
  always @(posedge mclk) begin
    if (rst) begin
      div_q <= {`DIV_W{1'b0}};
      pclk_prev_q <= 1'b0;
      rdy_extra_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_s;
      rdy_extra_q <= rdy_s;
      if (state_q == S_IDLE || tick) begin
        div_q <= {`DIV_W{1'b0}};
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // with internal timing, one unit never shorter than the minimum transition spacing
  assign tick = cfg_q[`CFG_EXT_PCLK] ? (pclk_s & ~pclk_prev_q)
              : (div_q == (`MIN_TRANS_CYC - 1));

  // ==========================================================
  // ready handling
  assign rdy_raw = cfg_q[`CFG_RDY_ASYNC] ? rdy_extra_q : rdy_s;
  assign rdy_active = rdy_raw ^ ~cfg_q[`CFG_RDY_POL];

  // ==========================================================
  // sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    capture = 1'b0;
    start = reg_wr && reg_addr == `REG_CMD && reg_wdata[`CMD_GO] && state_q == S_IDLE
            && (!reg_wdata[`CMD_RNW] || buf_in_ready);
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_AB;
          cnt_d = phase_len(S_AB, cfg_q);
        end
      end
      S_AB, S_C, S_D, S_F: begin
        if (tick) begin
          if (cnt_q > `LEN_ONE) begin
            cnt_d = cnt_q - `LEN_ONE;
          end else begin
            state_d = next_phase(state_q, cfg_q);
            cnt_d = phase_len(state_d, cfg_q);
          end
        end
      end
      S_E: begin
        if (tick) begin
          if (cnt_q > `LEN_ONE) begin
            cnt_d = cnt_q - `LEN_ONE;
          end else if (cfg_q[`CFG_RDY_EN] && !rdy_active) begin
            cnt_d = `LEN_ONE;
          end else begin
            state_d = next_phase(S_E, cfg_q);
            cnt_d = phase_len(state_d, cfg_q);
            capture = rnw_q;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
        cnt_d = `LEN_ZERO;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= `LEN_ZERO;
      rnw_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (start) begin
        rnw_q <= reg_wdata[`CMD_RNW];
      end
    end
  end

  // ==========================================================
  // read data capture and buffer
  assign cap_data = multiplexed_mode ? shared_s : dbus_s;

  word_buf2 #(
    .W(`DW)
  ) word_buf2_inst (
    .mclk(mclk),
    .rst(rst),
    .in_valid(capture),
    .in_ready(buf_in_ready),
    .in_data(cap_data),
    .out_valid(rd_word_valid),
    .out_ready(rd_word_ready),
    .out_data(rd_word),
    .level(buf_level)
  );

  // ==========================================================
  // bus pins
  always @(posedge mclk) begin
    if (rst) begin
      cs_n <= 1'b1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      byte_high_enable_n <= 1'b1;
      address_bus <= `ADDR_RST;
      shared_addr_data_lines_o <= `DATA_RST;
      shared_addr_data_lines_oe <= 1'b0;
      data_bus_o <= `DATA_RST;
      data_bus_oe <= 1'b0;
      last_rdata_q <= `DATA_RST;
    end else begin
      cs_n <= (state_d == S_IDLE) || (state_d == S_F);
      byte_high_enable_n <= (state_d == S_IDLE);
      ale <= multiplexed_mode && state_d == S_AB;
      rd_n <= !(rnw_q && state_d == S_E);
      wr_n <= !(!rnw_q && state_d == S_E);
      if (state_q == S_IDLE && state_d == S_AB) begin
        address_bus <= addr_q;
      end
      if (capture) begin
        last_rdata_q <= cap_data;
      end
      if (multiplexed_mode && (state_d == S_AB || state_d == S_C)) begin
        shared_addr_data_lines_o <= addr_q[`DW-1:0];
        shared_addr_data_lines_oe <= 1'b1;
      end else if (multiplexed_mode && !rnw_q && (state_d == S_D || state_d == S_E || state_d == S_F)) begin
        shared_addr_data_lines_o <= wdata_q;
        shared_addr_data_lines_oe <= 1'b1;
      end else begin
        shared_addr_data_lines_oe <= 1'b0;
      end
      if (!multiplexed_mode && !rnw_q && (state_d == S_D || state_d == S_E || state_d == S_F)) begin
        data_bus_o <= wdata_q;
        data_bus_oe <= 1'b1;
      end else begin
        data_bus_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register file
  always @(posedge mclk) begin
    if (rst) begin
      cfg_q <= `CFG_RST;
      addr_q <= `ADDR_RST;
      wdata_q <= `DATA_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_CFG: cfg_q <= reg_wdata[`CFG_W-1:0];
        `REG_ADDR: addr_q <= reg_wdata[`AW-1:0];
        `REG_WDATA: wdata_q <= reg_wdata[`DW-1:0];
        default: ;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `RDATA_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CFG: reg_rdata <= {14'h0000, cfg_q};
        `REG_ADDR: reg_rdata <= {8'h00, addr_q};
        `REG_WDATA: reg_rdata <= {16'h0000, wdata_q};
        `REG_STAT: reg_rdata <= {16'h0000, 6'h00, buf_level, rnw_q, state_q == S_IDLE, state_q};
        `REG_RDATA: reg_rdata <= {16'h0000, last_rdata_q};
        default: reg_rdata <= `RDATA_RST;
      endcase
    end else begin
      reg_rdata <= `RDATA_RST;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/pin_sync2.v ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter W = 1
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] pin,
  output reg [W-1:0] sync
);
  reg [W-1:0] meta_q;
  always @(posedge mclk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync <= {W{1'b0}};
    end else begin
      meta_q <= pin;
      sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/word_buf2.v ====
// two-entry valid/ready buffer for read words
`timescale 1ns/1ps
`default_nettype none
module word_buf2 #(
  parameter W = 16
) (
  input wire mclk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [1:0] level
);
  reg [W-1:0] mem_q [0:1];
  reg wptr_q;
  reg rptr_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rptr_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end
  always @(posedge mclk) begin
    if (rst) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wptr_q <= ~wptr_q;
      end
      if (pop) begin
        rptr_q <= ~rptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ==== test/ebu_seq_asserts.sv ====
// assertion checker for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ebu_defs_defs.vh"
module ebu_seq_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reference_clock_out,
  input wire logic cs_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [`AW-1:0] address_bus,
  input wire logic [`DW-1:0] shared_addr_data_lines_o,
  input wire logic shared_addr_data_lines_oe,
  input wire logic data_bus_oe,
  input wire logic rd_word_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ====================
  // bus cycle properties
  property p_ref_clk; @(negedge mclk) reference_clock_out; endproperty
  property p_strobe_in_cyc; (!rd_n || !wr_n) |-> !cs_n; endproperty
  property p_rw_excl; rd_n || wr_n; endproperty
  property p_cs_min; $fell(cs_n) |-> !cs_n [*4]; endproperty
  property p_acc_min; ($fell(rd_n) || $fell(wr_n)) |-> (!rd_n || !wr_n) [*2]; endproperty
  property p_ale_addr;
    ale |-> shared_addr_data_lines_oe && wr_n && shared_addr_data_lines_o == address_bus[15:0];
  endproperty
  property p_one_mode; !(data_bus_oe && shared_addr_data_lines_oe); endproperty
  property p_addr_hold; (!cs_n && !$past(cs_n)) |-> $stable(address_bus); endproperty
  property p_capture; $rose(rd_n) |-> ##[0:2] rd_word_valid; endproperty
  a_ref_clk: assert property (p_ref_clk) else $error("reference clock low");
  a_strobe_in_cyc: assert property (p_strobe_in_cyc) else $error("strobe outside cycle");
  a_rw_excl: assert property (p_rw_excl) else $error("read and write together");
  a_cs_min: assert property (p_cs_min) else $error("cycle too short");
  a_acc_min: assert property (p_acc_min) else $error("access too short");
  a_ale_addr: assert property (p_ale_addr) else $error("latch phase wrong");
  a_one_mode: assert property (p_one_mode) else $error("both buses driven");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_capture: assert property (p_capture) else $error("read word lost");
  c_read: cover property ($rose(rd_n));
  c_write: cover property ($rose(wr_n));
  c_mux: cover property (ale ##1 !ale);
endmodule
bind external_bus_cycle_sequencer ebu_seq_asserts ebu_seq_asserts_inst (.mclk, .rst, .reference_clock_out,
  .cs_n, .ale, .rd_n, .wr_n, .address_bus, .shared_addr_data_lines_o, .shared_addr_data_lines_oe,
  .data_bus_oe, .rd_word_valid);
`default_nettype wire

// ==== test/ext_mem_model.sv ====
// attached memory model with ready handshake
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic mclk,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic mux,
  input wire logic pol,
  input wire logic [7:0] dly,
  input wire logic [23:0] address_bus,
  input wire logic [15:0] sh_o,
  output logic [15:0] rd_data,
  output logic ready_pin
);
  logic [15:0] lat = 16'h0;
  logic [15:0] last = 16'h0;
  logic [7:0] cnt = 8'h0;
  wire [15:0] val = (mux ? lat : address_bus[15:0]) ^ 16'h5a5a;
  always @(posedge mclk) begin
    if (ale)
      lat <= sh_o;
    cnt <= (!rd_n || !wr_n) ? cnt + 8'h1 : 8'h0;
    if (!rd_n)
      last <= val;
  end
  // released bus shows the inverse of the last word
  assign rd_data = !rd_n ? val : ~last;
  assign ready_pin = (cnt >= dly) ? pol : !pol;
endmodule
`default_nettype wire

// ==== test/external_bus_cycle_sequencer_test.sv ====
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ebu_defs_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module external_bus_cycle_sequencer_test;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, phase_clk = 0, pc_en = 0;
  logic mux = 0, pol = 1, rd_word_ready = 1;
  logic [7:0] reg_addr = 8'h0, dly = 8'd13;
  logic [31:0] reg_wdata = 32'h0;
  int error_cnt = 0, check_count = 0;
  wire [31:0] reg_rdata;
  wire [23:0] address_bus;
  wire [15:0] sh_o, db_o, rd_word, mem_d;
  wire reference_clock_out, ready_pin, cs_n, ale, rd_n, wr_n, sh_oe, db_oe, rd_word_valid, bhe_n;
  wire [15:0] sh_i = sh_oe ? sh_o : mem_d;
  wire [15:0] db_i = db_oe ? db_o : mem_d;
  always #5 mclk = ~mclk;
  always #80 phase_clk = pc_en ? ~phase_clk : 1'b0;
  external_bus_cycle_sequencer external_bus_cycle_sequencer_inst (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reference_clock_out, .phase_clk, .ready_pin, .cs_n, .ale, .rd_n, .wr_n,
    .byte_high_enable_n(bhe_n), .address_bus, .shared_addr_data_lines_i(sh_i), .shared_addr_data_lines_o(sh_o),
    .shared_addr_data_lines_oe(sh_oe), .data_bus_i(db_i), .data_bus_o(db_o), .data_bus_oe(db_oe),
    .rd_word_valid, .rd_word_ready, .rd_word);
  ext_mem_model ext_mem_model_inst (.mclk, .cs_n, .rd_n, .wr_n, .ale, .mux, .pol, .dly, .address_bus,
    .sh_o, .rd_data(mem_d), .ready_pin);
  // ====================
  // register bus tasks
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle; counts chip-select and strobe cycles
  task automatic cyc(input [31:0] cfg, input [23:0] a, input rnw, output int cs, output int acc);
    bit seen;
    cs = 0;
    acc = 0;
    seen = 0;
    wr(`REG_CFG, cfg);
    wr(`REG_ADDR, {8'h0, a});
    wr(`REG_WDATA, 32'h0000c3a5);
    wr(`REG_CMD, {30'h0, rnw, 1'b1});
    for (int i = 0; i < 400 && !(seen && cs_n); i++) begin
      #1;
      if (!cs_n) `CHK("addr", a, address_bus)
      if (!cs_n) `CHK("bhe", 1'b0, bhe_n)
      if (!wr_n) `CHK("wdata", 16'hc3a5, mux ? sh_o : db_o)
      if (!wr_n) `CHK("ale_low", 1'b0, ale)
      cs += !cs_n;
      acc += (!rd_n || !wr_n);
      seen = seen || !cs_n;
      @(posedge mclk);
    end
    if (!cs_n) begin
      error_cnt++;
      end_of_test;
    end
    repeat (40) @(posedge mclk);
  endtask
  // ====================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    `CHK("cs_n", 1'b1, cs_n)
    rd(`REG_CFG, d);
    `CHK("cfg", {14'h0, `CFG_RST}, d)
    rd(8'h20, d);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_lengths;
    int cs, acc;
    logic [31:0] cf [3] = '{32'h1, 32'h5, 32'h1ffa};
    int ecs [3] = '{4, 12, 76};
    int eac [3] = '{2, 2, 64};
    for (int k = 0; k < 3; k++) begin
      cyc(cf[k], 24'h123456 + k, 1'b0, cs, acc);
      `CHK("cs_len", ecs[k], cs)
      `CHK("acc_len", eac[k], acc)
    end
  endtask
  task automatic t_read;
    int cs, acc, a0;
    logic [31:0] d;
    mux <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      pol <= (k != 1);
      cyc(32'h120c1 | (k == 1 ? 0 : 32'h4000) | (k == 2 ? 32'h8000 : 0), 24'h00a5c0 + k, 1'b1, cs, acc);
      if (k == 0)
        a0 = acc;
      `CHK("wait", 1'b1, acc >= 12 && acc <= 24)
      rd(`REG_RDATA, d);
      `CHK("rdata", (32'ha5c0 + k) ^ 32'h5a5a, d)
    end
    `CHK("async", 1'b1, acc > a0)
    cyc(32'h10001, 24'h00beef, 1'b0, cs, acc);
    `CHK("mux_wr", 4, cs)
    mux <= 1'b0;
  endtask
  task automatic t_stream;
    int cs, acc;
    logic [31:0] d;
    @(posedge mclk);
    rd_word_ready <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      cyc(32'h000c1, 24'h000100 + k, 1'b1, cs, acc);
      `CHK("accept", k < 2, cs > 0)
    end
    rd(`REG_STAT, d);
    `CHK("level", 2'h2, d[9:8])
    `CHK("first", 16'h5b5a, rd_word)
    @(posedge mclk);
    rd_word_ready <= 1'b1;
    @(posedge mclk);
    #1 `CHK("second", 16'h5b5b, rd_word)
    @(posedge mclk);
    #1 `CHK("empty", 1'b0, rd_word_valid)
  endtask
  task automatic t_ext;
    int cs, acc;
    pc_en = 1'b1;
    cyc(32'h20001, 24'h0000aa, 1'b0, cs, acc);
    pc_en = 1'b0;
    `CHK("ext_len", 1'b1, cs >= 16 && acc >= 14)
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_lengths;
    t_read;
    t_stream;
    t_ext;
    end_of_test;
  end
endmodule
`default_nettype wire
